// >>> shared/adcop_pkg.sv
package adcop_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths and clock
    localparam int RES_W     = 16;
    localparam int BUS_W     = 16;
    localparam int CLK_NS    = 100;

    // Pin positions on the shared data bus when the serial port is chosen
    localparam int PIN_DIV_LO    = 2;
    localparam int PIN_DIV_HI    = 3;
    localparam int PIN_CLK_SRC   = 4;
    localparam int PIN_FRAME_POL = 5;
    localparam int PIN_CLK_INV   = 6;
    localparam int PIN_READ_MODE = 7;
    localparam int PIN_SERIAL_DATA_OUT     = 8;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    // A serial clock needs at least two system cycles per period
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 2) ? 2 : c;
    endfunction : min_cycles

    localparam int DIV_NS_00  = 25;
    localparam int DIV_NS_01  = 50;
    localparam int DIV_NS_10  = 100;
    localparam int DIV_NS_11  = 200;
    localparam int DIV_CYC_00 = min_cycles(DIV_NS_00);
    localparam int DIV_CYC_01 = min_cycles(DIV_NS_01);
    localparam int DIV_CYC_10 = min_cycles(DIV_NS_10);
    localparam int DIV_CYC_11 = min_cycles(DIV_NS_11);

    // Longest idle time between starts in the fastest mode
    localparam int FAST_MAX_GAP_NS  = 1000000;
    localparam int FAST_MAX_GAP_CYC = FAST_MAX_GAP_NS / CLK_NS;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and encodings
    localparam logic [RES_W-1:0] WORD_RST = 16'h0000;

    typedef enum logic [1:0] {
        CM_NORMAL = 2'h0,
        CM_FAST   = 2'h1,
        CM_LOWPOW = 2'h2
    } adcop_mode_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_LOW  = 2'h1,
        TX_HIGH = 2'h3,
        TX_GAP  = 2'h2
    } adcop_tx_t;

endpackage : adcop_pkg

// >>> src/adcop_sync.sv
`timescale 1ns/1ps

module adcop_sync
    import adcop_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    // Levels from outside the clock domain
    input  wire logic [W-1:0] async_in,
    // Levels safe to use
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } adcop_sync_st_t;

    adcop_sync_st_t st_r;
    adcop_sync_st_t st_nxt;

    if (W < 1) begin : g_chk
        $error("adcop_sync: width must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////
    // The first stage feeds only the second
    always_comb begin
        st_nxt        = st_r;
        st_nxt.stage1 = async_in;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stage2;

endmodule : adcop_sync

// >>> src/adcop_port.sv
`timescale 1ns/1ps
// Contract
// RULE_01: Byte order pin swaps result bytes.
// RULE_02: Code format low inverts result MSB.
// RULE_03: Fast high, low-power low: fastest mode.
// RULE_04: Host keeps minimum start rate in fastest.
// RULE_05: Fast low keeps accuracy at any rate.
// RULE_06: Low-power high, fast low: reduced power.
// RULE_07: Port type selects parallel or serial.
// RULE_08: Serial mode floats data lines 0-1.
// RULE_09: Parallel mode drives bits 2-6 normally.
// RULE_10: Master read-after-convert: bits 2-3 divide clock.
// RULE_11: Other serial modes float divider pins.
// RULE_12: Master drives internal serial clock out.
// RULE_13: Slave shifts on host clock, chip-select gated.
// RULE_14: Frame polarity pin sets frame active level.
// RULE_15: Clock invert pin inverts serial clock.
// RULE_16: Divider codes give 25/50/100/200 ns periods; with the 100 ns clock the code gives 200 ns for all four codes.
// RULE_17: Read mode: during or after conversion.
// RULE_18: Serial data shifts out MSB first.
// RULE_19: Slave updates on rising or falling edge.
// RULE_20: Both mode pins low: normal; both high unsupported.

module adcop_port
    import adcop_pkg::*;
#(
    parameter int MAX_GAP_CYC = FAST_MAX_GAP_CYC
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // Configuration pins
    input  wire logic             byte_order_select,
    input  wire logic             output_code_format,
    input  wire logic             fast_mode_select,
    input  wire logic             low_power_select,
    input  wire logic             port_type_select,
    input  wire logic             cs_n,
    // Shared data bus pin
    input  wire logic [BUS_W-1:0] d_in,
    output logic      [BUS_W-1:0] d_out,
    output logic      [BUS_W-1:0] d_oe,
    // Serial clock pin
    input  wire logic             sclk_in,
    output logic                  sclk_out,
    output logic                  sclk_oe,
    // Frame indicator pin
    output logic                  frame_out,
    output logic                  frame_oe,
    // Converter core, same clock
    input  wire logic             conv_start,
    input  wire logic [RES_W-1:0] result_data,
    input  wire logic             result_valid,
    // Status
    output adcop_mode_t           conv_mode,
    output logic                  mode_unsupported,
    output logic                  rate_too_slow
);

    localparam int GAP_W  = $clog2(MAX_GAP_CYC + 1);
    localparam int SYNC_W = 13;
    localparam int CNT_W  = 8;
    localparam int BIT_W  = 5;

    if (MAX_GAP_CYC < 2) begin : g_chk_gap
        $error("adcop_port: gap limit must be at least two cycles");
    end
    if (DIV_CYC_11 / 2 >= (1 << CNT_W)) begin : g_chk_div
        $error("adcop_port: divider count does not fit its counter");
    end

    typedef struct packed {
        logic [RES_W-1:0] word;
        adcop_mode_t      mode;
        logic             unsup;
        logic [GAP_W-1:0] gap;
        logic             slow;
        adcop_tx_t        tx;
        logic [RES_W-1:0] shreg;
        logic [BIT_W-1:0] bits;
        logic [CNT_W-1:0] cnt;
        logic             sclk;
        logic             frame;
        logic             sdata;
        logic             ext_d;
    } adcop_port_st_t;

    adcop_port_st_t st_r;
    adcop_port_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_lvl;

    assign sync_raw = {d_in[PIN_READ_MODE:PIN_DIV_LO], sclk_in, cs_n, port_type_select,
                       low_power_select, fast_mode_select, output_code_format,
                       byte_order_select};

    adcop_sync #(
        .W        (SYNC_W)
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in (sync_raw),
        .sync_out (sync_lvl)
    );

    logic       byte_swap;
    logic       straight_bin;
    logic       fast_sel;
    logic       lowpow_sel;
    logic       serial_sel;
    logic       cs_lo;
    logic       ext_clk;
    logic [1:0] div_code;
    logic       slave_sel;
    logic       frame_pol;
    logic       clk_inv;
    logic       read_during;

    assign byte_swap    = sync_lvl[0];
    assign straight_bin = sync_lvl[1];
    assign fast_sel     = sync_lvl[2];
    assign lowpow_sel   = sync_lvl[3];
    assign serial_sel   = sync_lvl[4];
    assign cs_lo        = ~sync_lvl[5];
    assign ext_clk      = sync_lvl[6];
    assign div_code     = sync_lvl[8:7];
    assign slave_sel    = sync_lvl[9];
    assign frame_pol    = sync_lvl[10];
    assign clk_inv      = sync_lvl[11];
    assign read_during  = sync_lvl[12];

    ////////////////////////////////////////////////////////////////////////
    // Serial timing selection
    logic             master;
    logic             rd_after;
    logic [CNT_W-1:0] half_cyc;

    assign master   = serial_sel & ~slave_sel;                          // [RULE_12]
    assign rd_after = master & ~read_during;                            // [RULE_10]

    always_comb begin
        half_cyc = CNT_W'(DIV_CYC_00 / 2);
        if (rd_after) begin                                             // [RULE_10]
            case (div_code)                                             // [RULE_16]
                2'h0:    half_cyc = CNT_W'(DIV_CYC_00 / 2);
                2'h1:    half_cyc = CNT_W'(DIV_CYC_01 / 2);
                2'h2:    half_cyc = CNT_W'(DIV_CYC_10 / 2);
                2'h3:    half_cyc = CNT_W'(DIV_CYC_11 / 2);
                default: half_cyc = CNT_W'(DIV_CYC_00 / 2);
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    logic m_trigger;
    logic s_edge;
    logic gap_hit;

    // Read during convert sends the word still held from the last result
    assign m_trigger = master & (read_during ? conv_start : result_valid);  // [RULE_17]
    // Slave edge comes from the synchronised pin level, so the host clock
    // must be well below the system clock; fast host clocks are not caught
    assign s_edge    = clk_inv ? (~ext_clk & st_r.ext_d)                 // [RULE_19]
                               : (ext_clk & ~st_r.ext_d);
    // Hit marks the step onto the limit only; the counter then rests at the
    // limit, so a later start is free to clear the flag
    assign gap_hit   = (st_r.gap == GAP_W'(MAX_GAP_CYC - 1));

    always_comb begin
        st_nxt       = st_r;
        st_nxt.ext_d = ext_clk;

        if (result_valid) begin
            st_nxt.word = {result_data[RES_W-1] ^ ~straight_bin,        // [RULE_02]
                           result_data[RES_W-2:0]};
        end

        // Mode decode; both pins high falls back to normal and is flagged
        st_nxt.unsup = fast_sel & lowpow_sel;                           // [RULE_20]
        if (fast_sel && !lowpow_sel) begin
            st_nxt.mode = CM_FAST;                                      // [RULE_03]
        end else if (lowpow_sel && !fast_sel) begin
            st_nxt.mode = CM_LOWPOW;                                    // [RULE_06]
        end else begin
            st_nxt.mode = CM_NORMAL;                                    // [RULE_20]
        end

        // Watch the host start rate only in the fastest mode; a hit in the
        // same cycle as a start still raises the flag
        if (st_r.mode == CM_FAST) begin                                 // [RULE_04]
            st_nxt.slow = gap_hit | (st_r.slow & ~conv_start);
            if (conv_start) begin
                st_nxt.gap = '0;
            end else if (st_r.gap != GAP_W'(MAX_GAP_CYC)) begin
                st_nxt.gap = st_r.gap + GAP_W'(1);
            end
        end else begin
            st_nxt.slow = 1'b0;                                         // [RULE_05]
            st_nxt.gap  = '0;
        end

        if (!serial_sel) begin
            st_nxt.tx    = TX_IDLE;
            st_nxt.sclk  = 1'b0;
            st_nxt.frame = 1'b0;
        end else if (slave_sel) begin
            st_nxt.tx    = TX_IDLE;
            st_nxt.sclk  = 1'b0;
            st_nxt.frame = 1'b0;
            if (result_valid) begin
                st_nxt.shreg = st_nxt.word;
                st_nxt.sdata = st_nxt.word[RES_W-1];                    // [RULE_18]
            end else if (cs_lo && s_edge) begin                         // [RULE_13]
                st_nxt.sdata = st_r.shreg[RES_W-2];
                st_nxt.shreg = {st_r.shreg[RES_W-2:0], read_during};
            end
        end else begin
            case (st_r.tx)
                TX_IDLE: begin
                    st_nxt.sclk  = 1'b0;
                    st_nxt.frame = 1'b0;
                    if (m_trigger) begin
                        st_nxt.shreg = result_valid ? st_nxt.word : st_r.word;
                        st_nxt.sdata = st_nxt.shreg[RES_W-1];           // [RULE_18]
                        st_nxt.bits  = BIT_W'(RES_W);
                        st_nxt.cnt   = half_cyc;
                        st_nxt.frame = 1'b1;
                        st_nxt.tx    = TX_LOW;
                    end
                end
                TX_LOW: begin
                    if (st_r.cnt <= CNT_W'(1)) begin
                        st_nxt.sclk = 1'b1;
                        st_nxt.cnt  = half_cyc;
                        st_nxt.tx   = TX_HIGH;
                    end else begin
                        st_nxt.cnt = st_r.cnt - CNT_W'(1);
                    end
                end
                TX_HIGH: begin
                    if (st_r.cnt <= CNT_W'(1)) begin
                        st_nxt.sclk = 1'b0;
                        st_nxt.cnt  = half_cyc;
                        st_nxt.bits = st_r.bits - BIT_W'(1);
                        if (st_r.bits == BIT_W'(1)) begin
                            st_nxt.frame = 1'b0;
                            st_nxt.tx    = TX_GAP;
                        end else begin
                            st_nxt.sdata = st_r.shreg[RES_W-2];         // [RULE_18]
                            st_nxt.shreg = {st_r.shreg[RES_W-2:0], 1'b0};
                            st_nxt.tx    = TX_LOW;
                        end
                    end else begin
                        st_nxt.cnt = st_r.cnt - CNT_W'(1);
                    end
                end
                TX_GAP: begin
                    st_nxt.tx = TX_IDLE;
                end
                default: begin
                    st_nxt.tx = TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r       <= '0;
            st_r.word  <= WORD_RST;
            st_r.mode  <= CM_NORMAL;
            st_r.tx    <= TX_IDLE;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    // Every driven pin floats while chip select is high, except during reset, when the cleared synchroniser reads it as low
    always_comb begin
        d_out = '0;
        d_oe  = '0;
        if (!serial_sel) begin                                          // [RULE_07]
            d_out = byte_swap ? {st_r.word[7:0], st_r.word[15:8]}       // [RULE_01]
                              : st_r.word;
            d_oe  = {BUS_W{cs_lo}};                                     // [RULE_09]
        end else begin
            // Bits 0-1 and the divider pins stay off in all serial modes
            d_out[PIN_SERIAL_DATA_OUT] = st_r.sdata;                              // [RULE_08] [RULE_11]
            d_oe[PIN_SERIAL_DATA_OUT]  = cs_lo;
        end
    end

    assign sclk_out  = st_r.sclk ^ clk_inv;                             // [RULE_15]
    assign sclk_oe   = master & cs_lo;                                  // [RULE_12]
    assign frame_out = st_r.frame ^ frame_pol;                          // [RULE_14]
    assign frame_oe  = master & cs_lo;

    assign conv_mode        = st_r.mode;
    assign mode_unsupported = st_r.unsup;
    assign rate_too_slow    = st_r.slow;

endmodule : adcop_port

// >>> tb/adcop_sva.sv
`timescale 1ns/1ps
module adcop_sva
    import adcop_pkg::*;
(
    // Clock and reset
    input logic             clock,
    input logic             rst_n,
    // Pins
    input logic             byte_order_select,
    input logic             output_code_format,
    input logic             fast_mode_select,
    input logic             low_power_select,
    input logic             port_type_select,
    input logic             cs_n,
    input logic [BUS_W-1:0] d_in,
    input logic [BUS_W-1:0] d_out,
    input logic [BUS_W-1:0] d_oe,
    input logic             sclk_out,
    input logic             sclk_oe,
    input logic             frame_out,
    input logic             frame_oe,
    // Core and status
    input logic [RES_W-1:0] result_data,
    input logic             result_valid,
    input adcop_mode_t      conv_mode,
    input logic             mode_unsupported
);
    // Pins are synchronised, so only judge them once they stood still
    logic [3:0]  calm_r;
    logic [11:0] pins_q;
    wire  [11:0] pins = {d_in[7:2], port_type_select, cs_n, byte_order_select,
                         output_code_format, fast_mode_select, low_power_select};
    wire         calm = (calm_r >= 4'h5) && (pins == pins_q);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            calm_r <= 4'h0;
            pins_q <= 12'h000;
        end else begin
            pins_q <= pins;
            calm_r <= (pins != pins_q) ? 4'h0 : ((calm_r == 4'hF) ? calm_r : calm_r + 4'h1);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    chk_serial_float: assert property (calm && port_type_select |-> d_oe[1:0] == 2'h0)
        else $error("low data lines driven in serial mode");
    chk_parallel_drive: assert property (calm && !port_type_select && !cs_n |-> &d_oe)
        else $error("parallel bus not fully driven");
    chk_div_pins: assert property (calm && port_type_select |-> d_oe[3:2] == 2'h0)
        else $error("divider pins driven in serial mode");
    chk_master_clk: assert property (calm && port_type_select && !d_in[4] && !cs_n |-> sclk_oe && frame_oe)
        else $error("master clock or frame not driven");
    chk_slave_quiet: assert property (calm && port_type_select && d_in[4] |-> !sclk_oe && !frame_oe)
        else $error("clock driven in slave mode");
    chk_mode_sel: assert property (calm |-> conv_mode == ((fast_mode_select && !low_power_select) ? CM_FAST :
        ((low_power_select && !fast_mode_select) ? CM_LOWPOW : CM_NORMAL))) else $error("wrong conversion mode");
    chk_mode_bad: assert property (calm |-> mode_unsupported == (fast_mode_select && low_power_select))
        else $error("unsupported flag wrong");
    chk_frame_level: assert property (calm && frame_oe && $changed(sclk_out) |-> $past(frame_out) == !d_in[5])
        else $error("frame not active while clocking");
    chk_clk_idle: assert property (calm && sclk_oe && frame_out == d_in[5] |-> sclk_out == d_in[6])
        else $error("idle serial clock sense wrong");
    chk_word_cap: assert property (calm && result_valid && !port_type_select && !byte_order_select |=>
        d_out == ($past(result_data) ^ {!$past(output_code_format), 15'h0000})) else $error("parallel word wrong");
endmodule : adcop_sva

bind adcop_port adcop_sva chk_u (.clock(clock), .rst_n(rst_n),
    .byte_order_select(byte_order_select), .output_code_format(output_code_format),
    .fast_mode_select(fast_mode_select), .low_power_select(low_power_select),
    .port_type_select(port_type_select), .cs_n(cs_n), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .frame_out(frame_out), .frame_oe(frame_oe),
    .result_data(result_data), .result_valid(result_valid), .conv_mode(conv_mode),
    .mode_unsupported(mode_unsupported));

// >>> tb/adcop_host.sv
`timescale 1ns/1ps
module adcop_host
    import adcop_pkg::*;
(
    // System side
    input  logic clock,
    // Serial pins
    input  logic sdata,
    input  logic sclk_out,
    input  logic frame_out,
    input  logic frame_pol,
    input  logic clk_inv,
    output logic sclk_in
);
    localparam int HALF = 4;
    logic [RES_W-1:0] m_word = 16'h0000;
    int               m_cnt = 0;
    logic             prev_clk = 1'b0;
    logic             act = 1'b0;
    // Host clock rests at its idle level outside frames
    assign sclk_in = clk_inv ^ act;
    // Sample on the internal rising edge, when the bit stands still
    always @(posedge clock) begin
        if (frame_out != frame_pol && !prev_clk && (sclk_out ^ clk_inv) && m_cnt < RES_W) begin
            m_word <= {m_word[RES_W-2:0], sdata};
            m_cnt <= m_cnt + 1;
        end
        prev_clk <= sclk_out ^ clk_inv;
    end
    // Slow host clock: well under a quarter of the system rate
    task automatic slave_read(input int n, output logic [RES_W-1:0] word);
        word = 16'h0000;
        repeat (n) begin
            repeat (HALF) @(posedge clock);
            #10 word = {word[RES_W-2:0], sdata};
            act = 1'b1;
            repeat (HALF) @(posedge clock);
            #10 act = 1'b0;
        end
    endtask : slave_read
endmodule : adcop_host

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import adcop_pkg::*;
    localparam int SETTLE = 6;
    logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, cs_n = 1'b0;
    logic byte_order_select = 1'b0, output_code_format = 1'b0, port_type_select = 1'b0;
    logic fast_mode_select = 1'b0, low_power_select = 1'b0, conv_start = 1'b0;
    logic result_valid = 1'b0, sclk_in, sclk_out, sclk_oe, frame_out, frame_oe;
    logic mode_unsupported, rate_too_slow;
    logic [15:0] d_in = 16'h0000, result_data = 16'h0000, d_out, d_oe;
    adcop_mode_t conv_mode;
    int error_cnt = 0, n_checks = 0;

    always #(CLK_NS / 2) clock = ~clock;

    adcop_port #(.MAX_GAP_CYC(20)) dut_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .byte_order_select(byte_order_select), .output_code_format(output_code_format),
        .fast_mode_select(fast_mode_select), .low_power_select(low_power_select),
        .port_type_select(port_type_select), .cs_n(cs_n), .d_in(d_in), .d_out(d_out),
        .d_oe(d_oe), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .frame_out(frame_out), .frame_oe(frame_oe), .conv_start(conv_start),
        .result_data(result_data), .result_valid(result_valid), .conv_mode(conv_mode),
        .mode_unsupported(mode_unsupported), .rate_too_slow(rate_too_slow));
    adcop_host host_u (.clock(clock), .sdata(d_out[PIN_SERIAL_DATA_OUT]), .sclk_out(sclk_out),
        .frame_out(frame_out), .frame_pol(d_in[5]), .clk_inv(d_in[6]), .sclk_in(sclk_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask : tick
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            fast_mode_select = i[0];
            low_power_select = i[1];
            tick(SETTLE);
            check("mode", conv_mode, i == 1 ? CM_FAST : (i == 2 ? CM_LOWPOW : CM_NORMAL));
            check("unsupported", mode_unsupported, i == 3);
        end
    endtask : t_modes
    task automatic t_parallel();
        logic [15:0] w;
        for (int i = 0; i < 4; i++) begin
            byte_order_select = i[0];
            output_code_format = i[1];
            tick(SETTLE);
            result_data = 16'h1A3C;
            result_valid = 1'b1;
            tick(1);
            result_valid = 1'b0;
            tick(1);
            w = 16'h1A3C ^ {!i[1], 15'h0000};
            if (i[0]) w = {w[7:0], w[15:8]};
            check("d_out", d_out, w);
            check("d_oe", d_oe, 16'hFFFF);
        end
        cs_n = 1'b1;
        tick(SETTLE);
        check("d_oe deselected", d_oe, 16'h0000);
        cs_n = 1'b0;
    endtask : t_parallel
    task automatic t_rate();
        fast_mode_select = 1'b1;
        low_power_select = 1'b0;
        tick(SETTLE);
        repeat (4) begin
            conv_start = 1'b1;
            tick(1);
            conv_start = 1'b0;
            tick(9);
            check("rate kept", rate_too_slow, 1'b0);
        end
        tick(16);
        check("rate slow", rate_too_slow, 1'b1);
        conv_start = 1'b1;
        tick(1);
        conv_start = 1'b0;
        tick(2);
        check("rate cleared", rate_too_slow, 1'b0);
        fast_mode_select = 1'b0;
        tick(30);
        check("rate normal", rate_too_slow, 1'b0);
    endtask : t_rate
    task automatic t_master();
        int k;
        logic [15:0] w;
        port_type_select = 1'b1;
        output_code_format = 1'b1;
        for (int i = 0; i < 5; i++) begin
            d_in = {8'h00, i == 4, i[1], i[0], 1'b0, i[1:0], 2'h0};
            w = (i == 4) ? 16'hC35D : 16'hC35A + 16'(i);
            tick(SETTLE);
            check("serial oe", d_oe[3:0], 4'h0);
            host_u.m_cnt = 0;
            if (i == 4) conv_start = 1'b1;
            else result_valid = 1'b1;
            result_data = w;
            tick(1);
            conv_start = 1'b0;
            result_valid = 1'b0;
            k = 0;
            while (host_u.m_cnt < 16 && k < 200) begin
                tick(1);
                k++;
            end
            check("master word", host_u.m_word, w);
            check("master cycles", 16'(k), 16'h0020);
        end
    endtask : t_master
    task automatic t_slave();
        logic [15:0] w;
        for (int i = 0; i < 2; i++) begin
            d_in = {8'h00, 1'b1, i[0], 1'b0, 1'b1, 4'h0};
            tick(SETTLE);
            result_data = i[0] ? 16'h4D18 : 16'hB2E7;
            result_valid = 1'b1;
            tick(1);
            result_valid = 1'b0;
            cs_n = 1'b1;
            tick(SETTLE);
            host_u.slave_read(3, w);
            cs_n = 1'b0;
            tick(SETTLE);
            host_u.slave_read(16, w);
            check("slave word", w, i[0] ? 16'h4D18 : 16'hB2E7);
        end
    endtask : t_slave
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        #10 rst_n = 1'b1;
        tick(4);
        t_modes();
        t_parallel();
        t_rate();
        t_master();
        t_slave();
        report_and_stop();
    end
    initial begin
        #(CLK_NS * 20000);
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_top
